// ==== sclksw_clock_switch.sv ====
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module sclksw_clock_switch #(
	parameter int LOCK_CYCLES = sclksw_pkg::LOCK_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// configuration and neighbour control
	input wire logic clockSwitchEnableCfg,
	input wire logic [2:0] mainOscModeCfg,
	input wire logic secondaryOscEnable,
	// oscillator sources
	input wire logic mainOscIn,
	input wire logic secOscIn,
	// sleep and wake
	input wire logic sleepReq,
	input wire logic wakeExtReset,
	input wire logic wakeWatchdog,
	input wire logic wakeInterrupt,
	// core side
	output logic sysClk,
	output logic coreHold,
	output logic [1:0] qPhase,
	output logic mainOscRun,
	output logic inSleep,
	// osc out pin and port bit 6
	input wire logic oscOutPinIn,
	output logic oscOutPinOut,
	output logic oscOutPinOe,
	input wire logic portA6Out,
	input wire logic portA6Oe,
	output logic portA6In
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic riseSeen(input logic s2, input logic s3, input logic stable);
		riseSeen = s2 & s3 & ~stable;
	endfunction

	function automatic logic isCrystal(input logic [2:0] m);
		isCrystal = (m == sclksw_pkg::MODE_LOW_XTAL) || (m == sclksw_pkg::MODE_STD_XTAL) ||
			(m == sclksw_pkg::MODE_FAST_XTAL) || (m == sclksw_pkg::MODE_FAST_X4);
	endfunction

	function automatic logic isIoMode(input logic [2:0] m);
		isIoMode = (m == sclksw_pkg::MODE_RES_CAP_IO) || (m == sclksw_pkg::MODE_EXT_CLK_IO);
	endfunction

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [2:0] mainSync_r;
	logic [2:0] secSync_r;
	logic [2:0] pinSync_r;
	logic mainStable_r, secStable_r;
	logic mainRise, secRise;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mainSync_r <= 3'h0;
			secSync_r <= 3'h0;
			pinSync_r <= 3'h0;
		end
		else
		begin
			mainSync_r <= {mainSync_r[1:0], mainOscIn};
			secSync_r <= {secSync_r[1:0], secOscIn};
			pinSync_r <= {pinSync_r[1:0], oscOutPinIn};
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mainStable_r <= 1'b0;
			secStable_r <= 1'b0;
			portA6In <= 1'b0;
		end
		else
		begin
			if (mainSync_r[1] == mainSync_r[2])
				mainStable_r <= mainSync_r[2];
			if (secSync_r[1] == secSync_r[2])
				secStable_r <= secSync_r[2];
			if (pinSync_r[1] == pinSync_r[2])
				portA6In <= pinSync_r[2];
		end
	end

	assign mainRise = riseSeen(mainSync_r[1], mainSync_r[2], mainStable_r);
	assign secRise = riseSeen(secSync_r[1], secSync_r[2], secStable_r);

	// ----------------------------------------
	// oscillator control register
	// ----------------------------------------
	logic selectSec_r;
	logic selAllowed;
	logic wrOscCtrl;

	assign selAllowed = !clockSwitchEnableCfg && secondaryOscEnable;
	assign wrOscCtrl = psel && penable && pwrite && (paddr == sclksw_pkg::OSC_CTRL_ADDR);

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			selectSec_r <= sclksw_pkg::OSC_CTRL_RESET;
		else if (!selAllowed)
			selectSec_r <= 1'b0;
		else if (wrOscCtrl)
			selectSec_r <= pwdata[sclksw_pkg::SELECT_BIT];
	end

	// ----------------------------------------
	// switch and sleep sequencer
	// ----------------------------------------
	sclksw_pkg::sclksw_state_e state_r;
	logic activeSec_r;
	logic targetSec_r;
	logic sleepPend_r;
	logic [1:0] phase_r;
	logic [3:0] syncCnt_r;
	logic [10:0] startCnt_r;
	logic [16:0] lockCnt_r;
	logic activeRise;
	logic targetRise;
	logic alignEdge;
	logic wake;
	logic startDone;
	logic lockDone;

	assign activeRise = activeSec_r ? secRise : mainRise;
	assign targetRise = targetSec_r ? secRise : mainRise;
	assign alignEdge = activeRise && (phase_r == sclksw_pkg::LAST_QUARTER);
	assign wake = wakeExtReset || wakeWatchdog || wakeInterrupt;
	assign startDone = mainRise &&
		(startCnt_r == 11'(sclksw_pkg::STARTUP_CYCLES - 1));
	assign lockDone = (lockCnt_r == 17'(LOCK_CYCLES - 1));

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			sleepPend_r <= 1'b0;
		else if (sleepReq)
			sleepPend_r <= 1'b1;
		else if (state_r == sclksw_pkg::ST_SLEEP)
			sleepPend_r <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r <= sclksw_pkg::ST_RUN;
			activeSec_r <= 1'b0;
			targetSec_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				sclksw_pkg::ST_RUN:
				begin
					if (sleepPend_r || sleepReq || (selectSec_r != activeSec_r))
						state_r <= sclksw_pkg::ST_ALIGN;
				end
				sclksw_pkg::ST_ALIGN:
				begin
					if (alignEdge)
					begin
						if (sleepPend_r)
							state_r <= sclksw_pkg::ST_SLEEP;
						else if (selectSec_r != activeSec_r)
						begin
							targetSec_r <= selectSec_r;
							if (!selectSec_r && isCrystal(mainOscModeCfg))
								state_r <= sclksw_pkg::ST_STARTUP;
							else
								state_r <= sclksw_pkg::ST_SYNC;
						end
						else
							state_r <= sclksw_pkg::ST_RUN;
					end
				end
				sclksw_pkg::ST_SLEEP:
				begin
					if (wake)
					begin
						targetSec_r <= activeSec_r;
						if (!activeSec_r && isCrystal(mainOscModeCfg))
							state_r <= sclksw_pkg::ST_STARTUP;
						else
							state_r <= sclksw_pkg::ST_SYNC;
					end
				end
				sclksw_pkg::ST_STARTUP:
				begin
					if (startDone)
					begin
						if (mainOscModeCfg == sclksw_pkg::MODE_FAST_X4)
							state_r <= sclksw_pkg::ST_LOCK;
						else
							state_r <= sclksw_pkg::ST_SYNC;
					end
				end
				sclksw_pkg::ST_LOCK:
				begin
					if (lockDone)
						state_r <= sclksw_pkg::ST_SYNC;
				end
				sclksw_pkg::ST_SYNC:
				begin
					if (targetRise && (syncCnt_r == 4'(sclksw_pkg::SYNC_EDGES - 1)))
					begin
						activeSec_r <= targetSec_r;
						state_r <= sclksw_pkg::ST_RUN;
					end
				end
				default:
					state_r <= sclksw_pkg::ST_RUN;
			endcase
		end
	end

	// ----------------------------------------
	// delay counters
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			syncCnt_r <= 4'h0;
		else if (state_r != sclksw_pkg::ST_SYNC)
			syncCnt_r <= 4'h0;
		else if (targetRise)
			syncCnt_r <= syncCnt_r + 4'h1;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			startCnt_r <= 11'h000;
		else if (state_r != sclksw_pkg::ST_STARTUP)
			startCnt_r <= 11'h000;
		else if (mainRise)
			startCnt_r <= startCnt_r + 11'h001;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			lockCnt_r <= 17'h00000;
		else if (state_r != sclksw_pkg::ST_LOCK)
			lockCnt_r <= 17'h00000;
		else
			lockCnt_r <= lockCnt_r + 17'h00001;
	end

	// ----------------------------------------
	// instruction phase and system clock
	// ----------------------------------------
	logic running;
	logic activeLevel;
	logic targetLevel;
	logic finishing;

	assign running = (state_r == sclksw_pkg::ST_RUN) || (state_r == sclksw_pkg::ST_ALIGN);
	assign activeLevel = activeSec_r ? secStable_r : mainStable_r;
	assign targetLevel = targetSec_r ? secStable_r : mainStable_r;
	assign finishing = (state_r == sclksw_pkg::ST_SYNC) && targetRise &&
		(syncCnt_r == 4'(sclksw_pkg::SYNC_EDGES - 1));

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			phase_r <= sclksw_pkg::FIRST_QUARTER;
		else if (running && activeRise)
			phase_r <= phase_r + 2'h1;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			sysClk <= 1'b0;
		else if (state_r == sclksw_pkg::ST_RUN)
			sysClk <= activeLevel;
		else if (state_r == sclksw_pkg::ST_ALIGN)
			sysClk <= alignEdge ? sysClk : activeLevel;
		else if (finishing)
			sysClk <= targetLevel;
		else
			sysClk <= sysClk & activeLevel;
	end

	assign coreHold = !running;
	assign qPhase = phase_r;
	assign inSleep = (state_r == sclksw_pkg::ST_SLEEP);
	assign mainOscRun = !inSleep;

	// ----------------------------------------
	// osc out pin
	// ----------------------------------------
	logic divOut_r;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			divOut_r <= 1'b0;
		else if (inSleep)
			divOut_r <= 1'b0;
		else
			divOut_r <= phase_r[1];
	end

	always_comb
	begin
		if (isIoMode(mainOscModeCfg))
		begin
			oscOutPinOut = portA6Out;
			oscOutPinOe = portA6Oe;
		end
		else if (isCrystal(mainOscModeCfg))
		begin
			oscOutPinOut = 1'b0;
			oscOutPinOe = 1'b0;
		end
		else
		begin
			oscOutPinOut = divOut_r;
			oscOutPinOe = 1'b1;
		end
	end

	// ----------------------------------------
	// apb read side
	// ----------------------------------------
	logic addrHit;

	always_comb
	begin
		prdata = 32'h00000000;
		addrHit = 1'b1;
		if (paddr == sclksw_pkg::OSC_CTRL_ADDR)
			prdata = {31'h00000000, selectSec_r};
		else if (paddr == sclksw_pkg::SWITCH_STATUS_ADDR)
			prdata = {26'h0000000, phase_r, inSleep, coreHold, targetSec_r, activeSec_r};
		else
			addrHit = 1'b0;
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !addrHit;

endmodule

`default_nettype wire

// ==== sclksw_pkg.sv ====
// What this block does
// - switching allowed only when enable config is 0
// - select bit 0 main, 1 secondary
// - nrst clears the select bit; the reset wake leaves it
// - secondary disabled: writes ignored, bit reads 0
// - select writable only when both enables allow
// - bits 7 to 1 read zero, ignore writes
// - wait eight target rising edges before handover
// - no system clock pulse narrower than sources
// - to secondary: freeze at first quarter, resume after eight
// - back to crystal main: add startup delay
// - startup delay is 1024 main oscillator cycles
// - fast x4 crystal: startup plus 2 ms lock
// - resistor-capacitor and external clock: eight cycles only
// - sleep stops clocks, holds core at first quarter
// - leave sleep on reset, watchdog or interrupt
// - sleep: out pin low, or port bit 6
// - resistor-capacitor: out pin carries source divided by 4
`default_nettype none

package sclksw_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [11:0] OSC_CTRL_ADDR = 12'h000;
	localparam logic [11:0] SWITCH_STATUS_ADDR = 12'h004;
	localparam int SELECT_BIT = 0;
	localparam logic OSC_CTRL_RESET = 1'b0;

	// ----------------------------------------
	// main oscillator modes
	// ----------------------------------------
	localparam logic [2:0] MODE_LOW_XTAL = 3'h0;
	localparam logic [2:0] MODE_STD_XTAL = 3'h1;
	localparam logic [2:0] MODE_FAST_XTAL = 3'h2;
	localparam logic [2:0] MODE_FAST_X4 = 3'h3;
	localparam logic [2:0] MODE_RES_CAP = 3'h4;
	localparam logic [2:0] MODE_RES_CAP_IO = 3'h5;
	localparam logic [2:0] MODE_EXT_CLK = 3'h6;
	localparam logic [2:0] MODE_EXT_CLK_IO = 3'h7;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int SYNC_EDGES = 8;
	localparam int STARTUP_CYCLES = 1024;
	localparam int CLK_PERIOD_NS = 20;
	localparam int LOCK_TIME_NS = 2000000;
	localparam int LOCK_CYCLES = LOCK_TIME_NS / CLK_PERIOD_NS;
	localparam logic [1:0] FIRST_QUARTER = 2'h0;
	localparam logic [1:0] LAST_QUARTER = 2'h3;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_ALIGN,
		ST_STARTUP,
		ST_LOCK,
		ST_SYNC,
		ST_SLEEP
	} sclksw_state_e;

endpackage

`default_nettype wire

// ==== sclksw_osc_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module sclksw_osc_model (
	// control
	input wire logic mainOscRun,
	// sources
	output logic mainOscIn,
	output logic secOscIn
);
	// main stops while stopped by sleep, secondary runs free
	initial mainOscIn = 1'b0;
	initial secOscIn = 1'b0;
	always #60 mainOscIn = (mainOscRun !== 1'b0) ? !mainOscIn : 1'b0;
	always #200 secOscIn = !secOscIn;
endmodule

`default_nettype wire

// ==== sclksw_checker.sv ====
`timescale 1ns/100ps
`default_nettype none

module sclksw_checker (
	// watched ports
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic clockSwitchEnableCfg,
	input wire logic [2:0] mainOscModeCfg,
	input wire logic secondaryOscEnable,
	input wire logic coreHold,
	input wire logic [1:0] qPhase,
	input wire logic mainOscRun,
	input wire logic inSleep,
	input wire logic oscOutPinOut,
	input wire logic oscOutPinOe,
	input wire logic portA6Out,
	input wire logic portA6Oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire rd0 = psel && penable && !pwrite && paddr == 12'h000;
	wire noSw = clockSwitchEnableCfg || !secondaryOscEnable;
	wire io = mainOscModeCfg == 3'h5 || mainOscModeCfg == 3'h7;
	wire rcOrExt = mainOscModeCfg == 3'h4 || mainOscModeCfg == 3'h6;
	ro_bits_a: assert property (rd0 |-> prdata[31:1] == 31'h0)
		else $error("control upper bits set");
	sel_forced_a: assert property (rd0 && noSw && $past(noSw) |-> !prdata[0])
		else $error("select not forced clear");
	sleep_stop_a: assert property (inSleep |-> coreHold && !mainOscRun)
		else $error("clocks run in sleep");
	sleep_q1_a: assert property ($rose(inSleep) |-> qPhase == 2'h0)
		else $error("sleep not at first quarter");
	freeze_q1_a: assert property ($rose(coreHold) |-> qPhase == 2'h0)
		else $error("freeze not at first quarter");
	frozen_a: assert property (coreHold && $past(coreHold) |-> $stable(qPhase))
		else $error("phase moved while frozen");
	sync_len_a: assert property ($rose(coreHold) |-> coreHold [*8])
		else $error("hold too short");
	io_pass_a: assert property (io |-> oscOutPinOut == portA6Out && oscOutPinOe == portA6Oe)
		else $error("port bit not passed");
	sleep_low_a: assert property (rcOrExt && inSleep && $past(inSleep) |-> oscOutPinOe && !oscOutPinOut)
		else $error("out pin not low in sleep");
	rc_drive_a: assert property (mainOscModeCfg == 3'h4 && $stable(mainOscModeCfg) && !inSleep |-> oscOutPinOe)
		else $error("out pin not driven");
endmodule

bind sclksw_clock_switch sclksw_checker u_sclksw_checker (.core_clk, .nrst, .psel, .penable,
	.pwrite, .paddr, .prdata, .clockSwitchEnableCfg, .mainOscModeCfg, .secondaryOscEnable,
	.coreHold, .qPhase, .mainOscRun, .inSleep, .oscOutPinOut, .oscOutPinOe, .portA6Out,
	.portA6Oe);

`default_nettype wire

// ==== sclksw_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module testbench;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic pready, pslverr, ev, sysClk, coreHold, mainOscRun, inSleep, pinOut, pinOe;
	logic swCfg = 1'b0, secEn = 1'b1, sleepReq = 1'b0, a6Out = 1'b0, a6Oe = 1'b0;
	logic pinIn = 1'b0, a6In;
	logic [2:0] wk = 3'h0, modeCfg = 3'h1;
	logic [1:0] qPhase;
	logic mainOscIn, secOscIn;
	int checks = 0, error_cnt = 0, cyc = 0, n, t;

	always #10 core_clk = ~core_clk;

	sclksw_osc_model u_sclksw_osc_model (.mainOscRun(mainOscRun), .mainOscIn(mainOscIn),
		.secOscIn(secOscIn));

	sclksw_clock_switch #(.LOCK_CYCLES(3000)) u_sclksw_clock_switch (.core_clk(core_clk),
		.nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.clockSwitchEnableCfg(swCfg), .mainOscModeCfg(modeCfg), .secondaryOscEnable(secEn),
		.mainOscIn(mainOscIn), .secOscIn(secOscIn), .sleepReq(sleepReq),
		.wakeExtReset(wk[0]), .wakeWatchdog(wk[1]), .wakeInterrupt(wk[2]), .sysClk(sysClk),
		.coreHold(coreHold), .qPhase(qPhase), .mainOscRun(mainOscRun), .inSleep(inSleep),
		.oscOutPinIn(pinIn), .oscOutPinOut(pinOut), .oscOutPinOe(pinOe), .portA6Out(a6Out),
		.portA6Oe(a6Oe), .portA6In(a6In));

	task automatic test_done();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (checks > 0 && error_cnt == 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", s, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// counts raw rises of one source while the core is held
	task automatic hold(input logic sec);
		logic p, seen, s;
		seen = 1'b0;
		p = 1'b1;
		n = 0;
		for (t = 0; t < 30000 && !(seen && !coreHold); t++)
		begin
			@(posedge core_clk);
			s = sec ? secOscIn : mainOscIn;
			seen = seen | coreHold;
			if (coreHold && s && !p)
				n++;
			p = s;
		end
		chk("hold", {seen, coreHold}, 2'b10);
	endtask

	task automatic regs();
		apb(0, 12'h000, 32'h0);
		chk("rst", rv, 32'h0);
		swCfg <= 1'b1;
		apb(1, 12'h000, 32'hFFFFFFFF);
		apb(0, 12'h000, 32'h0);
		chk("cfg", rv, 32'h0);
		swCfg <= 1'b0;
		secEn <= 1'b0;
		apb(1, 12'h000, 32'hFFFFFFFF);
		apb(0, 12'h000, 32'h0);
		chk("secoff", rv, 32'h0);
		secEn <= 1'b1;
		apb(0, 12'h010, 32'h0);
		chk("unmap", ev, 1'b1);
	endtask

	task automatic round(input logic [2:0] m);
		modeCfg <= m;
		apb(1, 12'h000, 32'hFFFFFFFF);
		hold(1'b1);
		chk("tosec", n inside {[7:9]}, 1'b1);
		apb(0, 12'h000, 32'h0);
		chk("sel", rv, 32'h1);
		apb(0, 12'h004, 32'h0);
		chk("onsec", rv[0], 1'b1);
		apb(1, 12'h000, 32'h0);
		hold(1'b0);
		if (m < 3'h4)
			chk("ost", n >= 1031, 1'b1);
		else
			chk("nost", n inside {[7:9]}, 1'b1);
		if (m == 3'h3)
			chk("lock", t >= 9000, 1'b1);
	endtask

	task automatic nap(input int k);
		@(negedge core_clk);
		chk("rcoe", pinOe, 1'b1);
		@(posedge core_clk);
		sleepReq <= 1'b1;
		@(posedge core_clk);
		sleepReq <= 1'b0;
		for (t = 0; t < 100 && inSleep !== 1'b1; t++)
			@(negedge core_clk);
		repeat (2) @(negedge core_clk);
		chk("pins", {inSleep, mainOscRun, sysClk, pinOe, pinOut}, 5'h12);
		@(posedge core_clk);
		wk <= 3'h1 << k;
		@(posedge core_clk);
		wk <= 3'h0;
		hold(1'b0);
		chk("awake", inSleep, 1'b0);
	endtask

	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			error_cnt++;
			test_done();
		end
	end

	initial
	begin
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		regs();
		for (int m = 0; m < 8; m++)
			round(3'(m));
		apb(1, 12'h000, 32'h1);
		hold(1'b1);
		nrst <= 1'b0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		apb(0, 12'h004, 32'h0);
		chk("rstsrc", rv[0], 1'b0);
		modeCfg <= 3'h4;
		for (int k = 0; k < 3; k++)
			nap(k);
		chk("a6lo", a6In, 1'b0);
		modeCfg <= 3'h7;
		a6Out <= 1'b1;
		a6Oe <= 1'b1;
		pinIn <= 1'b1;
		repeat (6) @(negedge core_clk);
		chk("io", {pinOe, pinOut}, 2'b11);
		chk("a6in", a6In, 1'b1);
		test_done();
	end
endmodule

`default_nettype wire
